// [hw/dcs_pkg.sv]
// shared constants and types for the dma completion signalling block
package dcs_pkg;

    localparam int          DCS_AW            = 8;
    localparam int          DCS_DW            = 32;
    localparam int          DCS_EVW           = 64;

    // register byte offsets
    localparam logic [7:0]  DCS_OFS_CTRL      = 8'h00;
    localparam logic [7:0]  DCS_OFS_CHAIN_LO  = 8'h04;
    localparam logic [7:0]  DCS_OFS_CHAIN_HI  = 8'h08;
    localparam logic [7:0]  DCS_OFS_PEND_LO   = 8'h0C;
    localparam logic [7:0]  DCS_OFS_PEND_HI   = 8'h10;
    localparam logic [7:0]  DCS_OFS_IEN_LO    = 8'h14;
    localparam logic [7:0]  DCS_OFS_IEN_HI    = 8'h18;

    // channel control word fields
    localparam int          DCS_PRIV_LSB      = 24;
    localparam int          DCS_PRIV_W        = 4;
    localparam int          DCS_MID_CHAIN_BIT = 23;
    localparam int          DCS_FIN_CHAIN_BIT = 22;
    localparam int          DCS_MID_IRQ_BIT   = 21;
    localparam int          DCS_FIN_IRQ_BIT   = 20;
    localparam int          DCS_RSVD_BIT      = 19;
    localparam int          DCS_CODE_LSB      = 12;
    localparam int          DCS_CODE_W        = 6;
    localparam int          DCS_MODE_BIT      = 11;
    localparam logic [31:0] DCS_CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] DCS_CTRL_WR_MASK  = 32'h00F3_FF0F;
    localparam logic [31:0] DCS_WORD_ZERO     = 32'h0000_0000;
    localparam logic [63:0] DCS_EV_ZERO       = 64'h0000_0000_0000_0000;
    localparam logic [63:0] DCS_EV_ONE        = 64'h0000_0000_0000_0001;

    // one completion report from the transfer engine
    typedef struct packed {
        logic valid;
        logic final_tr;
    } dcs_cmpl_t;

    // avalon request bundle
    typedef struct packed {
        logic              read;
        logic              write;
        logic [DCS_AW-1:0] address;
        logic [3:0]        byteenable;
        logic [DCS_DW-1:0] writedata;
    } dcs_avs_req_t;

endpackage : dcs_pkg

// [hw/dcs_completion.sv]
// completion signalling: control word, chained event and pending registers
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
//
// Behaviour
// [R1] privilege tag loads from the writing master on any parameter write
// [R2] mid chain enable sets chained event bit at code on non-final requests
// [R3] final chain enable sets chained event bit at code on final request
// [R4] mid irq enable sets pending bit at code on non-final requests
// [R5] final irq enable sets pending bit at code on final request
// [R6] interrupt raised only while enable bit at pending position is set
// [R7] software writes zero into reserved bit 19 of the control word
// [R8] six-bit completion code selects the single bit to set
// [R9] mode 0 signals after data moved, mode 1 on request submission
// [R10] codes 32 to 63 land in the high register of each pair
// [R11] chaining and interrupt enables act independently on one completion
module dcs_completion
    import dcs_pkg::*;
(
    input  wire logic              CORE_CLK,
    input  wire logic              RESET,
    input  wire dcs_avs_req_t      AVS_REQ,
    input  wire logic [3:0]        AVS_PRIV_ID,
    input  wire logic              PARAMETER_SET_SET_WRITE,
    input  wire dcs_cmpl_t         TR_SUBMITTED,
    input  wire dcs_cmpl_t         TR_DONE,
    output logic [DCS_DW-1:0]      AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    output logic [DCS_EVW-1:0]     CHAINED_EVENTS,
    output logic                   CPU_IRQ
);

    ////////////////////////////////////////////////////////////////////////

    logic [DCS_DW-1:0]  ctrl_q;
    logic [DCS_EVW-1:0] chain_q;
    logic [DCS_EVW-1:0] pend_q;
    logic [DCS_EVW-1:0] ien_q;
    logic [DCS_DW-1:0]  rd_d;
    logic               wait_q;
    logic [DCS_DW-1:0]  be_mask;
    logic [DCS_DW-1:0]  wr_bits;
    logic               acc_wr;
    logic               acc_any;
    dcs_cmpl_t          ev;
    logic [DCS_CODE_W-1:0] code;
    logic [DCS_EVW-1:0] code_onehot;
    logic [DCS_EVW-1:0] chain_set;
    logic [DCS_EVW-1:0] pend_set;
    logic [DCS_EVW-1:0] chain_clr;
    logic [DCS_EVW-1:0] pend_clr;
    logic               irq_any;
    logic               do_chain;
    logic               do_pend;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, access lands when waitrequest is low

    assign acc_any = (AVS_REQ.read | AVS_REQ.write) & ~wait_q;
    assign acc_wr  = AVS_REQ.write & ~wait_q;
    assign be_mask = {{8{AVS_REQ.byteenable[3]}}, {8{AVS_REQ.byteenable[2]}},
                      {8{AVS_REQ.byteenable[1]}}, {8{AVS_REQ.byteenable[0]}}};
    // lanes applied once, used only by the write-one-to-clear decode
    assign wr_bits = AVS_REQ.writedata & be_mask;

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            wait_q <= 1'b1;
        else if (acc_any)
            wait_q <= 1'b1;
        else if (AVS_REQ.read | AVS_REQ.write)
            wait_q <= 1'b0;
    end

    assign AVS_WAITREQUEST = wait_q;

    always_comb
    begin
        rd_d = DCS_WORD_ZERO;
        unique case (AVS_REQ.address)
            DCS_OFS_CTRL:     rd_d = ctrl_q;
            DCS_OFS_CHAIN_LO: rd_d = chain_q[31:0];
            DCS_OFS_CHAIN_HI: rd_d = chain_q[63:32];
            DCS_OFS_PEND_LO:  rd_d = pend_q[31:0];
            DCS_OFS_PEND_HI:  rd_d = pend_q[63:32];
            DCS_OFS_IEN_LO:   rd_d = ien_q[31:0];
            DCS_OFS_IEN_HI:   rd_d = ien_q[63:32];
            default:          rd_d = DCS_WORD_ZERO;
        endcase
    end

    // data is prepared in the wait cycle so it stands at the accept edge
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            AVS_READDATA <= DCS_WORD_ZERO;
        else if (AVS_REQ.read & wait_q)
            AVS_READDATA <= rd_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // channel control word

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            ctrl_q <= DCS_CTRL_RESET;
        else
        begin
            if (acc_wr && AVS_REQ.address == DCS_OFS_CTRL)
                // tag, bit 19 and other reserved bits are not writable [R7]
                ctrl_q <= (ctrl_q & ~(be_mask & DCS_CTRL_WR_MASK))
                        | (AVS_REQ.writedata & be_mask & DCS_CTRL_WR_MASK);
            if ((acc_wr && AVS_REQ.address == DCS_OFS_CTRL) || PARAMETER_SET_SET_WRITE)
                ctrl_q[DCS_PRIV_LSB +: DCS_PRIV_W] <= AVS_PRIV_ID; // [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion decode

    // early mode trades data safety for latency: chain may fire mid-move
    assign ev = ctrl_q[DCS_MODE_BIT] ? TR_SUBMITTED : TR_DONE; // [R9]
    assign code = ctrl_q[DCS_CODE_LSB +: DCS_CODE_W]; // [R8]
    // upper half of the vector is the high register of each pair [R10]
    assign code_onehot = DCS_EV_ONE << code; // [R8] [R10]

    assign do_chain = ev.valid & (ev.final_tr ? ctrl_q[DCS_FIN_CHAIN_BIT]
                                              : ctrl_q[DCS_MID_CHAIN_BIT]);
    assign do_pend  = ev.valid & (ev.final_tr ? ctrl_q[DCS_FIN_IRQ_BIT]
                                              : ctrl_q[DCS_MID_IRQ_BIT]);
    // chain and interrupt paths are decided separately [R11]
    assign chain_set = do_chain ? code_onehot : DCS_EV_ZERO; // [R2] [R3]
    assign pend_set  = do_pend  ? code_onehot : DCS_EV_ZERO; // [R4] [R5]

    ////////////////////////////////////////////////////////////////////////
    // write-one-to-clear decode for both register pairs

    always_comb
    begin
        chain_clr = DCS_EV_ZERO;
        pend_clr  = DCS_EV_ZERO;
        if (acc_wr)
        begin
            unique case (AVS_REQ.address)
                DCS_OFS_CHAIN_LO: chain_clr[31:0]  = wr_bits;
                DCS_OFS_CHAIN_HI: chain_clr[63:32] = wr_bits;
                DCS_OFS_PEND_LO:  pend_clr[31:0]   = wr_bits;
                DCS_OFS_PEND_HI:  pend_clr[63:32]  = wr_bits;
                default:
                begin
                    chain_clr = DCS_EV_ZERO;
                    pend_clr  = DCS_EV_ZERO;
                end
            endcase
        end
    end

    // set beats clear so a completion in the clear cycle is kept
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            chain_q <= DCS_EV_ZERO;
        else
            chain_q <= (chain_q & ~chain_clr) | chain_set; // [R2] [R3]
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            pend_q <= DCS_EV_ZERO;
        else
            pend_q <= (pend_q & ~pend_clr) | pend_set; // [R4] [R5]
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            ien_q <= DCS_EV_ZERO;
        else if (acc_wr && AVS_REQ.address == DCS_OFS_IEN_LO)
            ien_q[31:0] <= (ien_q[31:0] & ~be_mask)
                         | (AVS_REQ.writedata & be_mask);
        else if (acc_wr && AVS_REQ.address == DCS_OFS_IEN_HI)
            ien_q[63:32] <= (ien_q[63:32] & ~be_mask)
                          | (AVS_REQ.writedata & be_mask);
    end

    assign CHAINED_EVENTS = chain_q;

    ////////////////////////////////////////////////////////////////////////
    // interrupt output

    assign irq_any = |(pend_q & ien_q);

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            CPU_IRQ <= 1'b0;
        else
            CPU_IRQ <= irq_any; // [R6]
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_PRIV_LOAD: assert property ( // [R1]
        @(posedge CORE_CLK) disable iff (RESET)
        PARAMETER_SET_SET_WRITE |=> ctrl_q[DCS_PRIV_LSB +: DCS_PRIV_W]
                            == $past(AVS_PRIV_ID))
        else $error("privilege tag not loaded from writing master");

    AST_MID_CHAIN: assert property ( // [R2]
        @(posedge CORE_CLK) disable iff (RESET)
        (ev.valid && !ev.final_tr && ctrl_q[DCS_MID_CHAIN_BIT])
        |=> chain_q[$past(code)])
        else $error("intermediate completion did not set chained bit");

    AST_MID_CHAIN_OFF: assert property ( // [R2]
        @(posedge CORE_CLK) disable iff (RESET)
        (ev.valid && !ev.final_tr && !ctrl_q[DCS_MID_CHAIN_BIT])
        |-> chain_set == DCS_EV_ZERO)
        else $error("chained bit set with intermediate chaining off");

    AST_FINAL_CHAIN: assert property ( // [R3]
        @(posedge CORE_CLK) disable iff (RESET)
        (ev.valid && ev.final_tr) |->
        (ctrl_q[DCS_FIN_CHAIN_BIT] ? chain_set == code_onehot
                                   : chain_set == DCS_EV_ZERO))
        else $error("final chaining does not follow its enable");

    AST_MID_IRQ: assert property ( // [R4]
        @(posedge CORE_CLK) disable iff (RESET)
        (ev.valid && !ev.final_tr) |->
        (ctrl_q[DCS_MID_IRQ_BIT] ? pend_set == code_onehot
                                 : pend_set == DCS_EV_ZERO))
        else $error("intermediate pending does not follow its enable");

    AST_FINAL_IRQ: assert property ( // [R5]
        @(posedge CORE_CLK) disable iff (RESET)
        (ev.valid && ev.final_tr && ctrl_q[DCS_FIN_IRQ_BIT])
        |=> pend_q[$past(code)])
        else $error("final completion did not set pending bit");

    AST_IRQ_GATE: assert property ( // [R6]
        @(posedge CORE_CLK) disable iff (RESET)
        ##1 CPU_IRQ == $past(irq_any))
        else $error("interrupt output not gated by enables");

    AST_MODE_EARLY: assert property ( // [R9]
        @(posedge CORE_CLK) disable iff (RESET)
        (ctrl_q[DCS_MODE_BIT] && !TR_SUBMITTED.valid)
        |-> chain_set == DCS_EV_ZERO && pend_set == DCS_EV_ZERO)
        else $error("early mode signalled without a submission");

    AST_HIGH_MAP: assert property ( // [R10]
        @(posedge CORE_CLK) disable iff (RESET)
        (do_chain && code[5]) |-> chain_set[31:0] == 32'h0000_0000
                                  && chain_set[63:32] != 32'h0000_0000)
        else $error("high code did not map into high register");

    AST_BOTH_SET: assert property ( // [R11]
        @(posedge CORE_CLK) disable iff (RESET)
        (do_chain && do_pend) |=> chain_q[$past(code)] && pend_q[$past(code)])
        else $error("chain and pending not both set");

    AST_ONE_WAIT: assert property (
        @(posedge CORE_CLK) disable iff (RESET)
        ((AVS_REQ.read || AVS_REQ.write) && wait_q) |=> !wait_q ##1 wait_q)
        else $error("waitrequest did not drop for exactly one cycle");

    AST_FINAL_CHAIN_SET: assert property ( // [R3]
        @(posedge CORE_CLK) disable iff (RESET)
        (ev.valid && ev.final_tr && ctrl_q[DCS_FIN_CHAIN_BIT])
        |=> chain_q[$past(code)])
        else $error("final completion did not set chained bit");

    AST_MID_IRQ_SET: assert property ( // [R4]
        @(posedge CORE_CLK) disable iff (RESET)
        (ev.valid && !ev.final_tr && ctrl_q[DCS_MID_IRQ_BIT])
        |=> pend_q[$past(code)])
        else $error("intermediate completion did not set pending bit");

    AST_FINAL_IRQ_OFF: assert property ( // [R5]
        @(posedge CORE_CLK) disable iff (RESET)
        (ev.valid && ev.final_tr && !ctrl_q[DCS_FIN_IRQ_BIT])
        |-> pend_set == DCS_EV_ZERO)
        else $error("pending bit set with final interrupt off");

    AST_CHAIN_ONE_BIT: assert property ( // [R8]
        @(posedge CORE_CLK) disable iff (RESET)
        $onehot0(chain_q & ~$past(chain_q)))
        else $error("more than one chained bit rose at once");

    AST_PEND_ONE_BIT: assert property ( // [R8]
        @(posedge CORE_CLK) disable iff (RESET)
        $onehot0(pend_q & ~$past(pend_q)))
        else $error("more than one pending bit rose at once");

    AST_CHAIN_NO_EVENT: assert property ( // [R2] [R3]
        @(posedge CORE_CLK) disable iff (RESET)
        !do_chain |=> (chain_q & ~$past(chain_q)) == DCS_EV_ZERO)
        else $error("chained bit rose without an enabled completion");

    AST_PEND_NO_EVENT: assert property ( // [R4] [R5]
        @(posedge CORE_CLK) disable iff (RESET)
        !do_pend |=> (pend_q & ~$past(pend_q)) == DCS_EV_ZERO)
        else $error("pending bit rose without an enabled completion");

    AST_TAG_HOLD: assert property ( // [R1]
        @(posedge CORE_CLK) disable iff (RESET)
        !(PARAMETER_SET_SET_WRITE || (acc_wr && AVS_REQ.address == DCS_OFS_CTRL))
        |=> $stable(ctrl_q[DCS_PRIV_LSB +: DCS_PRIV_W]))
        else $error("privilege tag changed without a parameter write");

    AST_RSVD_ZERO: assert property ( // [R7]
        @(posedge CORE_CLK) disable iff (RESET)
        !ctrl_q[DCS_RSVD_BIT])
        else $error("reserved control bit became set");

    AST_IRQ_MASKED: assert property ( // [R6]
        @(posedge CORE_CLK) disable iff (RESET)
        ((pend_q & ien_q) == DCS_EV_ZERO) |=> !CPU_IRQ)
        else $error("interrupt raised with every pending bit masked");

    AST_MODE_NORMAL: assert property ( // [R9]
        @(posedge CORE_CLK) disable iff (RESET)
        (!ctrl_q[DCS_MODE_BIT] && !TR_DONE.valid)
        |-> chain_set == DCS_EV_ZERO && pend_set == DCS_EV_ZERO)
        else $error("normal mode signalled before data moved");

    AST_HIGH_MAP_PEND: assert property ( // [R10]
        @(posedge CORE_CLK) disable iff (RESET)
        (do_pend && code[5]) |-> pend_set[31:0] == DCS_WORD_ZERO
                                 && pend_set[63:32] != DCS_WORD_ZERO)
        else $error("high code did not map into high pending register");

    AST_LOW_MAP: assert property ( // [R10]
        @(posedge CORE_CLK) disable iff (RESET)
        (do_chain && !code[5]) |-> chain_set[63:32] == DCS_WORD_ZERO)
        else $error("low code leaked into high chained register");

    AST_IRQ_FOLLOWS: assert property ( // [R6]
        @(posedge CORE_CLK) disable iff (RESET)
        ((pend_q & ien_q) != DCS_EV_ZERO) |=> CPU_IRQ)
        else $error("unmasked pending bit raised no interrupt");

endmodule : dcs_completion

// [testbench/dcs_host.sv]
// avalon master model standing in for the programming host
`timescale 1ns/1ps

module dcs_host
    import dcs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              wait_req,
    input  wire logic [DCS_DW-1:0] rdata,
    output dcs_avs_req_t           req
);
    initial req = '0;

    // holds the request until waitrequest is seen low at an edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] q);
        logic [31:0] wd;
        // only the control word has the reserved bit; others pass whole
        wd = (a == DCS_OFS_CTRL) ? d & ~(32'h1 << DCS_RSVD_BIT) : d;
        req <= '{read: !wr, write: wr, address: a, byteenable: be,
                 writedata: wd};
        @(posedge clk);
        while (wait_req)
            @(posedge clk);
        q = rdata;
        req <= '0;
        // one idle edge so the next call never drives in the same step
        @(posedge clk);
    endtask : xfer
endmodule : dcs_host

// [testbench/tb.sv]
// self-checking bench for the completion signalling block
`timescale 1ns/1ps

module tb;
    import dcs_pkg::*;
    logic         clk, rst, pws, wreq, irq;
    logic [3:0]   pid;
    dcs_avs_req_t req;
    dcs_cmpl_t    sub, done;
    logic [31:0]  rdat;
    logic [63:0]  chev;
    int           mismatches, n_compared;

    dcs_completion uut (.CORE_CLK(clk), .RESET(rst), .AVS_REQ(req),
        .AVS_PRIV_ID(pid), .PARAMETER_SET_SET_WRITE(pws), .TR_SUBMITTED(sub),
        .TR_DONE(done), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .CHAINED_EVENTS(chev), .CPU_IRQ(irq));
    dcs_host host (.clk(clk), .wait_req(wreq), .rdata(rdat), .req(req));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, 4'hF, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        host.xfer(1'b0, a, 32'h0, 4'hF, q);
    endtask : rd

    function automatic logic [31:0] ctl(logic [31:0] d, logic [3:0] p);
        return (d & DCS_CTRL_WR_MASK) | (32'(p) << DCS_PRIV_LSB);
    endfunction : ctl

    function automatic logic [63:0] bit_at(logic on, logic [5:0] c);
        return on ? DCS_EV_ONE << c : DCS_EV_ZERO;
    endfunction : bit_at

    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    initial
    begin
        logic [31:0] d, q, lo;
        logic [63:0] ech, epd, ien;
        logic [5:0]  code;
        logic        fin;
        rst = 1'b1;
        pws = 1'b0;
        pid = 4'h0;
        sub = '0;
        done = '0;
        mismatches = 0;
        n_compared = 0;
        void'($urandom(32'h4EE5));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(chev, DCS_EV_ZERO);
        rd(DCS_OFS_CTRL, q);
        chk(q, DCS_CTRL_RESET);
        rd(8'h40, q);
        chk(q, DCS_WORD_ZERO);
        for (int i = 0; i < 48; i++)
        begin
            // first passes hit both ends of each register half
            code = (i < 4) ? {i[1], {5{i[0]}}} : 6'($urandom);
            d = $urandom;
            d[DCS_CODE_LSB +: DCS_CODE_W] = code;
            fin = 1'($urandom);
            pid <= 4'($urandom);
            @(posedge clk);
            wr(DCS_OFS_CTRL, d);
            rd(DCS_OFS_CTRL, q);
            chk(q, ctl(d, pid));
            pid <= 4'($urandom);
            pws <= 1'b1;
            @(posedge clk);
            pws <= 1'b0;
            rd(DCS_OFS_CTRL, q);
            chk(q, ctl(d, pid));
            for (int a = 1; a < 5; a++)
                wr(8'(4 * a), 32'hFFFF_FFFF);
            chk(chev, DCS_EV_ZERO);
            ien = {$urandom, $urandom};
            ien[code] = 1'($urandom);
            wr(DCS_OFS_IEN_LO, ien[31:0]);
            wr(DCS_OFS_IEN_HI, ien[63:32]);
            // unselected completion source first, it must be ignored
            {sub, done} <= d[11] ? {2'b0, 1'b1, fin} : {1'b1, fin, 2'b0};
            @(posedge clk);
            {sub, done} <= d[11] ? {1'b1, fin, 2'b0} : {2'b0, 1'b1, fin};
            @(posedge clk);
            chk(chev, DCS_EV_ZERO);
            {sub, done} <= '0;
            ech = bit_at(fin ? d[22] : d[23], code);
            epd = bit_at(fin ? d[20] : d[21], code);
            @(posedge clk);
            chk(chev, ech);
            @(posedge clk);
            chk(irq, 64'(|(epd & ien)));
            rd(DCS_OFS_PEND_LO, lo);
            rd(DCS_OFS_PEND_HI, q);
            chk({q, lo}, epd);
            wr(DCS_OFS_IEN_LO, DCS_WORD_ZERO);
            wr(DCS_OFS_IEN_HI, DCS_WORD_ZERO);
            @(posedge clk);
            chk(irq, DCS_EV_ZERO);
        end
        // reset mid-run: flags, tag and enables all return to zero
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(chev, DCS_EV_ZERO);
        chk(irq, DCS_EV_ZERO);
        rd(DCS_OFS_CTRL, q);
        chk(q, DCS_CTRL_RESET);
        rd(DCS_OFS_PEND_HI, q);
        chk(q, DCS_WORD_ZERO);
        // byte lanes 0 and 2 only reach the enable register
        host.xfer(1'b1, DCS_OFS_IEN_LO, 32'hFFFF_FFFF, 4'h5, q);
        rd(DCS_OFS_IEN_LO, q);
        chk(q, 32'h00FF_00FF);
        complete_run();
    end
endmodule : tb
